// [hw/sbpc_pkg.sv]
package sbpc_pkg;
    // Command encodings on {cs_n, ras_n, cas_n, we_n}.
    localparam logic [3:0] CMD_INHIBIT = 4'h8;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACTIVE = 4'h3;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_BURST_STOP = 4'h6;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_MODE = 4'h0;
    // Address bit positions.
    localparam int ALL_BANK_POS = 10;
    localparam int WRITE_BURST_MODE_POS = 9;
    localparam int BURST_LEN_LSB = 0;
    localparam int CAS_LAT_LSB = 4;
    // Mode register reset value: burst 1, latency 2, burst writes.
    localparam logic [11:0] MODE_RESET = 12'h020;
    // Write recovery figures.
    localparam int TWR_NS = 14;
    localparam int CLK_NS = 40;
    localparam int TWR_CYC = (TWR_NS + CLK_NS - 1) / CLK_NS;
    // Register map.
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MODE = 4'h4;
    localparam logic [3:0] REG_BANKS = 4'h8;
    localparam int ST_PD_PRE = 0;
    localparam int ST_PD_ACT = 1;
    localparam int ST_SUSPEND = 2;
    localparam int ST_BURST = 3;
    typedef enum logic [3:0] {
        SBPC_IDLE = 4'b0001,
        SBPC_BURST_RD = 4'b0010,
        SBPC_BURST_WR = 4'b0100,
        SBPC_POWER_DOWN = 4'b1000
    } sbpc_state_t;
endpackage

// [hw/sbpc_core.sv]
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module sbpc_core #(
    parameter int BANKS = 4
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Memory command pins.
    input wire logic clk_gate,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [11:0] addr,
    // Device state.
    output logic [BANKS-1:0] bank_open,
    output logic [BANKS-1:0] bank_precharging,
    output logic power_down,
    output logic power_down_active,
    output logic suspended,
    output logic buffers_enabled,
    output logic [8:0] burst_count,
    output logic data_write_en,
    // Avalon-MM slave.
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    logic [11:0] mode_reg;
    sbpc_pkg::sbpc_state_t state;
    sbpc_pkg::sbpc_state_t next_state;
    logic [8:0] burst_len_left;
    logic [1:0] ap_bank;
    logic ap_active;
    logic [1:0] rec_count;
    logic [1:0] rec_bank;
    logic rec_pending;
    logic [2:0] cl_count;
    logic cl_pending;
    logic [1:0] cl_bank;
    logic cke_prev;
    logic rd_ack;

    // Command decode from the pins.
    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    wire [1:0] bank = {bank_select_high, bank_select_low};
    wire is_nop = (cmd == sbpc_pkg::CMD_NOP) || cs_n;
    wire all_banks = addr[sbpc_pkg::ALL_BANK_POS];
    // Commands only register on an internal edge not suppressed by the gate.
    // edge suppression
    wire int_edge = cke_prev && (state != sbpc_pkg::SBPC_POWER_DOWN);
    wire cmd_ok = int_edge && !cs_n;
    wire do_act = cmd_ok && cmd == sbpc_pkg::CMD_ACTIVE;
    wire do_pre = cmd_ok && cmd == sbpc_pkg::CMD_PRECHARGE;
    wire do_rd = cmd_ok && cmd == sbpc_pkg::CMD_READ;
    wire do_wr = cmd_ok && cmd == sbpc_pkg::CMD_WRITE;
    wire do_mode = cmd_ok && cmd == sbpc_pkg::CMD_MODE;
    wire do_stop = cmd_ok && cmd == sbpc_pkg::CMD_BURST_STOP;
    wire in_burst = (state == sbpc_pkg::SBPC_BURST_RD) || (state == sbpc_pkg::SBPC_BURST_WR);
    wire [2:0] bl_code = mode_reg[sbpc_pkg::BURST_LEN_LSB +: 3];
    // Full page is 256 columns; other codes are powers of two.
    wire [8:0] bl_prog = (bl_code == 3'd7) ? 9'h100 : (9'h001 << bl_code[1:0]);
    wire [8:0] bl_write = mode_reg[sbpc_pkg::WRITE_BURST_MODE_POS] ? 9'h001 : bl_prog;
    wire [2:0] cas_lat = mode_reg[sbpc_pkg::CAS_LAT_LSB +: 3];
    wire interrupt = ap_active && (do_rd || do_wr) && (bank != ap_bank);
    wire ap_req = addr[sbpc_pkg::ALL_BANK_POS];
    wire pd_enter = !clk_gate && is_nop && state == sbpc_pkg::SBPC_IDLE && int_edge;
    wire pd_exit = state == sbpc_pkg::SBPC_POWER_DOWN && clk_gate && is_nop;

    // Main state selection; a suspended edge keeps the state.
    always_comb begin
        next_state = state;
        case (state)
            sbpc_pkg::SBPC_IDLE: begin
                if (do_rd) begin
                    next_state = sbpc_pkg::SBPC_BURST_RD;
                end else if (do_wr) begin
                    next_state = sbpc_pkg::SBPC_BURST_WR;
                end else if (pd_enter) begin
                    next_state = sbpc_pkg::SBPC_POWER_DOWN;
                end
            end
            sbpc_pkg::SBPC_BURST_RD, sbpc_pkg::SBPC_BURST_WR: begin
                if (do_rd) begin
                    next_state = sbpc_pkg::SBPC_BURST_RD;
                end else if (do_wr) begin
                    next_state = sbpc_pkg::SBPC_BURST_WR;
                end else if (do_stop || do_pre || (int_edge && burst_len_left <= 9'h001)) begin
                    next_state = sbpc_pkg::SBPC_IDLE;
                end
            end
            sbpc_pkg::SBPC_POWER_DOWN: begin
                if (pd_exit) begin
                    next_state = sbpc_pkg::SBPC_IDLE;
                end
            end
            default: next_state = sbpc_pkg::SBPC_IDLE;
        endcase
    end

    // State, gate history and burst counter.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state <= sbpc_pkg::SBPC_IDLE;
            cke_prev <= 1'b1;
            burst_len_left <= 9'h000;
            burst_count <= 9'h000;
        end else begin
            state <= next_state;
            cke_prev <= clk_gate;
            if (do_rd) begin
                burst_len_left <= bl_prog;
                burst_count <= 9'h000;
            end else if (do_wr) begin
                burst_len_left <= bl_write;
                burst_count <= 9'h000;
            end else if (in_burst && int_edge && burst_len_left != 9'h000) begin
                burst_len_left <= burst_len_left - 9'h001;
                burst_count <= burst_count + 9'h001;
            end
        end
    end

    // Mode register and auto precharge tracking.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mode_reg <= sbpc_pkg::MODE_RESET;
            ap_active <= 1'b0;
            ap_bank <= 2'd0;
        end else begin
            if (do_mode) begin
                mode_reg <= addr;
            end
            if (do_rd || do_wr) begin
                ap_active <= ap_req;
                ap_bank <= bank;
            end else if (state != next_state && next_state == sbpc_pkg::SBPC_IDLE) begin
                ap_active <= 1'b0;
            end
        end
    end

    // Delayed precharge after an interrupted write; an interrupted read precharges at once, and a read cut off by another read also loads a latency count.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rec_pending <= 1'b0;
            rec_count <= 2'd0;
            rec_bank <= 2'd0;
            cl_pending <= 1'b0;
            cl_count <= 3'd0;
            cl_bank <= 2'd0;
        end else begin
            if (interrupt && state == sbpc_pkg::SBPC_BURST_WR) begin
                rec_pending <= 1'b1;
                rec_count <= 2'(sbpc_pkg::TWR_CYC);
                rec_bank <= ap_bank;
            end else if (rec_pending && rec_count != 2'd0) begin
                rec_count <= rec_count - 2'd1;
            end else begin
                rec_pending <= 1'b0;
            end
            if (interrupt && state == sbpc_pkg::SBPC_BURST_RD && do_rd) begin
                // old data runs out over latency
                cl_pending <= 1'b1;
                cl_count <= cas_lat;
                cl_bank <= ap_bank;
            end else if (cl_pending && cl_count != 3'd0) begin
                cl_count <= cl_count - 3'd1;
            end else begin
                cl_pending <= 1'b0;
            end
        end
    end

    // Per-bank row state.
    genvar b;
    generate
        for (b = 0; b < BANKS; b++) begin : g_bank
            wire hit = bank == 2'(b);
            wire pre_me = do_pre && (all_banks || hit);
            wire ap_rd_me = interrupt && state == sbpc_pkg::SBPC_BURST_RD && ap_bank == 2'(b);
            wire ap_wr_me = rec_pending && rec_count == 2'd0 && rec_bank == 2'(b);
            wire ap_end_me = ap_active && ap_bank == 2'(b) && in_burst
                && next_state == sbpc_pkg::SBPC_IDLE && !interrupt;
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    bank_open[b] <= 1'b0;
                    bank_precharging[b] <= 1'b0;
                end else begin
                    if (do_act && hit) begin
                        bank_open[b] <= 1'b1;
                    end else if (pre_me || ap_rd_me || ap_wr_me || ap_end_me) begin
                        bank_open[b] <= 1'b0;
                    end
                    bank_precharging[b] <= pre_me || ap_rd_me || ap_wr_me || ap_end_me;
                end
            end
        end
    endgenerate

    // Power state outputs.
    // variant chosen on entry
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            power_down_active <= 1'b0;
        end else if (pd_enter) begin
            power_down_active <= |bank_open;
        end
    end
    assign power_down = state == sbpc_pkg::SBPC_POWER_DOWN;
    // suspend while gate was low in a burst
    assign suspended = in_burst && !cke_prev;
    assign buffers_enabled = !power_down;
    // Write data is taken only on live write edges; the interrupted write stops here.
    assign data_write_en = state == sbpc_pkg::SBPC_BURST_WR && int_edge && !do_rd
        && burst_len_left != 9'h000;

    // Avalon slave: one wait cycle, then answer.
    wire acc = avs_read || avs_write;
    wire sel_status = avs_address == sbpc_pkg::REG_STATUS;
    wire sel_mode = avs_address == sbpc_pkg::REG_MODE;
    wire sel_banks = avs_address == sbpc_pkg::REG_BANKS;
    wire [31:0] status_word = {28'h000_0000, in_burst, suspended,
        power_down && power_down_active, power_down && !power_down_active};
    wire [31:0] rd_mux = sel_status ? status_word :
        sel_mode ? {20'h0_0000, mode_reg} :
        sel_banks ? {24'h00_0000, 4'(bank_precharging), 4'(bank_open)} : 32'h0000_0000;
    assign avs_waitrequest = acc && !rd_ack;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rd_ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            rd_ack <= acc && !rd_ack;
            if (acc && !rd_ack) begin
                avs_readdata <= rd_mux;
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/sbpc_core_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module sbpc_core_properties #(
    parameter int BANKS = 4
) (
    // Watched ports.
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_gate,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [11:0] addr,
    input wire logic [BANKS-1:0] bank_open,
    input wire logic [BANKS-1:0] bank_precharging,
    input wire logic power_down,
    input wire logic power_down_active,
    input wire logic suspended,
    input wire logic buffers_enabled,
    input wire logic [8:0] burst_count
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic gate_q;
    // Decoded command and the bank it names.
    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    // Command inhibit is chip-select high, whatever the other command pins show.
    wire nopish = cmd == sbpc_pkg::CMD_NOP || cs_n;
    wire pre = gate_q && !power_down && cmd == sbpc_pkg::CMD_PRECHARGE;
    wire [BANKS-1:0] sel = BANKS'(1) << {bank_select_high, bank_select_low};
    wire [BANKS-1:0] pre_mask = addr[10] ? {BANKS{1'b1}} : sel;
    // A command counts only when the gate was high one edge earlier.
    always_ff @(posedge sys_clk) begin
        gate_q <= resetn ? clk_gate : 1'b1;
    end
    chk_pre_all: assert property (pre && addr[10] |=> bank_open == '0)
        else $error("precharge all left a row open");
    chk_pre_one: assert property (pre && !addr[10] |=> (bank_open & $past(sel)) == '0)
        else $error("precharge left the named bank open");
    chk_pre_pulse: assert property (pre |=> (($past(pre_mask) & ~bank_precharging) == '0))
        else $error("selected bank gave no precharge pulse");
    chk_pd_entry: assert property ($rose(power_down) |-> $past(!clk_gate && nopish))
        else $error("power-down entered without gate low and no-op");
    chk_pd_kind: assert property ($rose(power_down) |-> power_down_active == ($past(bank_open) != '0))
        else $error("wrong power-down variant");
    chk_pd_buffers: assert property (buffers_enabled == !power_down)
        else $error("buffers enabled during power-down");
    chk_pd_deaf: assert property (power_down && cmd == sbpc_pkg::CMD_ACTIVE |=> $stable(bank_open))
        else $error("command taken during power-down");
    chk_pd_exit: assert property (power_down && clk_gate && nopish |=> !power_down)
        else $error("power-down not left");
    chk_pd_hold: assert property (power_down && !clk_gate |=> power_down)
        else $error("power-down left with gate low");
    chk_susp_hold: assert property (suspended |=> $stable(burst_count) && $stable(bank_open))
        else $error("state moved on a suppressed edge");
    chk_susp_mode: assert property (suspended |-> !power_down)
        else $error("suspend and power-down together");
endmodule
bind sbpc_core sbpc_core_properties #(.BANKS(BANKS)) chk (.sys_clk, .resetn, .clk_gate,
    .cs_n, .ras_n, .cas_n, .we_n, .bank_select_low, .bank_select_high, .addr, .bank_open,
    .bank_precharging,
    .power_down, .power_down_active, .suspended, .buffers_enabled, .burst_count);
`default_nettype wire

// [testbench/sbpc_ctl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sbpc_ctl_model (
    // Clock.
    input wire logic sys_clk,
    // Command side toward the device.
    output logic clk_gate,
    output logic [3:0] cmd,
    output logic [1:0] bank,
    output logic [11:0] addr
);
    // Idle pins before the first command.
    initial begin
        clk_gate = 1'b1;
        cmd = sbpc_pkg::CMD_NOP;
        bank = 2'h0;
        addr = 12'h000;
    end
    // One command cycle, then a no-op with the lines flipped so stale values never look valid.
    // command spacing
    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
        input logic g);
        @(posedge sys_clk);
        clk_gate <= g;
        cmd <= c;
        bank <= b;
        addr <= a;
        @(posedge sys_clk);
        cmd <= sbpc_pkg::CMD_NOP;
        bank <= ~b;
        addr <= ~a;
    endtask
    task automatic init(input int pause);
        repeat (pause) @(posedge sys_clk);
        issue(sbpc_pkg::CMD_REFRESH, 2'h0, 12'h000, 1'b1);
        issue(sbpc_pkg::CMD_REFRESH, 2'h0, 12'h000, 1'b1);
    endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define SBPC_CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    localparam logic [3:0] ACT = sbpc_pkg::CMD_ACTIVE;
    localparam logic [3:0] PRE = sbpc_pkg::CMD_PRECHARGE;
    localparam logic [3:0] NOP = sbpc_pkg::CMD_NOP;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_gate, power_down, buffers_enabled, data_write_en, avs_waitrequest;
    logic [3:0] cmd;
    logic [3:0] bank_open;
    logic [1:0] bank;
    logic [11:0] addr;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, rd;
    logic [31:0] lfsr = 32'h0000_d5b8;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    int wr_cnt = 0;
    int exp_open = 0;
    sbpc_core #(.BANKS(4)) uut (.sys_clk, .resetn, .clk_gate, .cs_n(cmd[3]), .ras_n(cmd[2]),
        .cas_n(cmd[1]), .we_n(cmd[0]), .bank_select_low(bank[0]), .bank_select_high(bank[1]),
        .addr, .bank_open, .bank_precharging(), .power_down, .power_down_active(),
        .suspended(), .buffers_enabled, .burst_count(), .data_write_en, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
    sbpc_ctl_model ctl (.sys_clk, .clk_gate, .cmd, .bank, .addr);
    // Clock of 40 ns.
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    // Write beats are counted on the falling edge, where the strobe has settled.
    always @(negedge sys_clk) begin
        if (data_write_en === 1'b1) wr_cnt++;
    end
    // A hang ends the run as a failure.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            give_verdict();
        end
    end
    function automatic logic [31:0] rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic give_verdict();
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Request held until a rising edge samples waitrequest low; data is taken at that edge.
    task automatic bus(input logic w, input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= lfsr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic cmdx(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
        input logic g);
        ctl.issue(c, b, a, g);
        if (c == ACT) exp_open |= 1 << b;
        if (c == PRE) exp_open &= a[10] ? 0 : ~(1 << b);
    endtask
    task automatic expect_open();
        @(negedge sys_clk);
        `SBPC_CHECK(bank_open, 4'(exp_open))
    endtask
    // Main sequence.
    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        `SBPC_CHECK(buffers_enabled, 1'b1)
        bus(1'b1, sbpc_pkg::REG_MODE, rd);
        bus(1'b0, sbpc_pkg::REG_MODE, rd);
        `SBPC_CHECK(rd, 32'(sbpc_pkg::MODE_RESET))
        bus(1'b0, 4'hc, rd);
        `SBPC_CHECK(rd, 32'h0000_0000)
        ctl.init(25);
        for (int i = 0; i < 4; i++) begin
            cmdx(ACT, 2'(i), lfsr[11:0], 1'b1);
            lfsr = rnd(lfsr);
        end
        bus(1'b0, sbpc_pkg::REG_BANKS, rd);
        `SBPC_CHECK(rd, 32'(exp_open))
        cmdx(PRE, lfsr[1:0], lfsr[11:0] & 12'hbff, 1'b1);
        expect_open();
        cmdx(PRE, lfsr[3:2], 12'h400 | lfsr[11:0], 1'b1);
        expect_open();
        // Precharge then active power-down; a command while down must be ignored.
        for (int v = 0; v < 2; v++) begin
            if (v == 1) cmdx(ACT, 2'h2, 12'h000, 1'b1);
            cmdx(NOP, 2'h0, 12'h000, 1'b0);
            ctl.issue(ACT, 2'h1, 12'h000, 1'b0);
            bus(1'b0, sbpc_pkg::REG_STATUS, rd);
            `SBPC_CHECK(rd, 32'(v + 1))
            @(negedge sys_clk);
            `SBPC_CHECK(buffers_enabled, 1'b0)
            cmdx(NOP, 2'h0, 12'h000, 1'b1);
            expect_open();
            `SBPC_CHECK(power_down, 1'b0)
        end
        cmdx(PRE, 2'h0, 12'h400, 1'b1);
        // Single-column writes, then a burst of eight suspended for two edges.
        for (int m = 0; m < 2; m++) begin
            cmdx(sbpc_pkg::CMD_MODE, 2'h0, m ? 12'h023 : 12'h223, 1'b1);
            cmdx(ACT, 2'h0, 12'h000, 1'b1);
            wr_cnt = 0;
            cmdx(sbpc_pkg::CMD_WRITE, 2'h0, 12'h000, 1'b1);
            if (m == 1) cmdx(NOP, 2'h0, 12'h000, 1'b0);
            cmdx(NOP, 2'h0, 12'h000, 1'b1);
            repeat (12) @(posedge sys_clk);
            `SBPC_CHECK(wr_cnt, m ? 8 : 1)
            cmdx(PRE, 2'h0, 12'h400, 1'b1);
        end
        // Auto-precharge access in bank 0 cut off by each access kind in bank 1.
        for (int k = 0; k < 4; k++) begin
            cmdx(ACT, 2'h0, 12'h000, 1'b1);
            cmdx(ACT, 2'h1, 12'h000, 1'b1);
            cmdx(k[1] ? sbpc_pkg::CMD_WRITE : sbpc_pkg::CMD_READ, 2'h0, 12'h400, 1'b1);
            cmdx(k[0] ? sbpc_pkg::CMD_WRITE : sbpc_pkg::CMD_READ, 2'h1, 12'h000, 1'b1);
            repeat (k[1] ? sbpc_pkg::TWR_CYC + 1 : 0) @(posedge sys_clk);
            exp_open = 2;
            expect_open();
            cmdx(PRE, 2'h0, 12'h400, 1'b1);
        end
        // An uninterrupted auto-precharge read of eight closes its bank when it ends.
        cmdx(ACT, 2'h0, 12'h000, 1'b1);
        cmdx(sbpc_pkg::CMD_READ, 2'h0, 12'h400, 1'b1);
        repeat (10) @(posedge sys_clk);
        exp_open = 0;
        expect_open();
        give_verdict();
    end
endmodule
`undef SBPC_CHECK
`default_nettype wire
